// ==== verilog/scc_cfg.svh ====
// constants for the system clock control register block
// assumes a plain register port with one-cycle read latency
`ifndef SCC_CFG_SVH
`define SCC_CFG_SVH
`define SCC_OFS_CTRL2     8'h08
`define SCC_OFS_FAST      8'h18
`define SCC_OFS_SLOW      8'h20
`define SCC_KEY_VAL       16'h5a5a
`define SCC_KEY_MSB       31
`define SCC_KEY_LSB       16
`define SCC_WAIT_MSB      6
`define SCC_WAIT_LSB      4
`define SCC_WAKE_BIT      3
`define SCC_LOCK_BIT      2
`define SCC_DBG_BIT       1
`define SCC_STABLE_BIT    15
`define SCC_DIV_MSB       14
`define SCC_DIV_LSB       11
`define SCC_FTRIM_MSB     10
`define SCC_SETTLE_MSB    11
`define SCC_SETTLE_LSB    10
`define SCC_STRIM_MSB     9
`define SCC_CTRL2_RST     3'h0
`define SCC_DIV_RST       4'h5
`define SCC_FTRIM_RST     11'h400
`define SCC_STRIM_RST     10'h200
`define SCC_SETTLE_RST    2'h0
`define SCC_SET0          9'h006
`define SCC_SET1          9'h012
`define SCC_SET2          9'h042
`define SCC_SET3          9'h102
`define SCC_FAST_SETTLE   9'h040
`endif

// ==== verilog/scc_pkg.sv ====
// types shared by the clock control block
// assumes the cfg header supplies all numbers
package scc_pkg;
  typedef enum logic [1:0] {
    SCC_OSC_OFF    = 2'b00,
    SCC_OSC_SETTLE = 2'b01,
    SCC_OSC_STABLE = 2'b10
  } scc_osc_state_t;
endpackage

// ==== verilog/scc_osc_settle.sv ====
// settle counter giving an oscillator stable flag
// assumes osc_tick is a synchronised one-cycle pulse per oscillator cycle
`timescale 1ns/100ps
`include "scc_cfg.svh"
module scc_osc_settle (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enable,
  input  wire logic       osc_tick,
  input  wire logic [8:0] settle_cycles,
  output logic            stable
);
  scc_pkg::scc_osc_state_t state_q;
  scc_pkg::scc_osc_state_t state_d;
  logic [8:0]              count_q;
  logic [8:0]              count_d;
  wire                     count_done = (count_q >= settle_cycles);

  always_comb begin
    state_d = state_q;
    count_d = count_q;
    unique case (state_q)
      scc_pkg::SCC_OSC_OFF: begin
        count_d = 9'h000;
        if (enable) state_d = scc_pkg::SCC_OSC_SETTLE;
      end
      scc_pkg::SCC_OSC_SETTLE: begin
        if (!enable) state_d = scc_pkg::SCC_OSC_OFF;
        else if (count_done) state_d = scc_pkg::SCC_OSC_STABLE;
        else if (osc_tick) count_d = 9'(count_q + 9'h001);
      end
      scc_pkg::SCC_OSC_STABLE: begin
        if (!enable) state_d = scc_pkg::SCC_OSC_OFF;
      end
      default: state_d = scc_pkg::SCC_OSC_OFF;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= scc_pkg::SCC_OSC_OFF;
      count_q <= 9'h000;
    end else begin
      state_q <= state_d;
      count_q <= count_d;
    end
  end

  assign stable = (state_q == scc_pkg::SCC_OSC_STABLE);
endmodule

// ==== verilog/scc_regs.sv ====
// system clock control registers: control two, fast and slow oscillator control
// assumes a plain register port; pin and oscillator inputs are asynchronous
`timescale 1ns/100ps
`include "scc_cfg.svh"
module scc_regs (
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic [7:0]  ADDR,
  input  wire logic [31:0] WDATA,
  input  wire logic        WR,
  input  wire logic        RD,
  output logic [31:0]      RDATA,
  input  wire logic        FAST_OSC_ENABLE,
  input  wire logic        SLOW_OSC_ENABLE,
  input  wire logic        DEEP_LOW_POWER_STATE,
  input  wire logic        WAKE_EVENT,
  input  wire logic        FAST_OSC_TICK,
  input  wire logic        SLOW_OSC_TICK,
  input  wire logic        CPU_RESET_ENABLE_A,
  output logic [1:0]       FETCH_WAIT_CYCLES,
  output logic             FORCE_FAST_CLOCK,
  output logic             RESET_ENABLE_A_RESET_REQ,
  output logic             DEBUG_PINS_GPIO,
  output logic             FAST_OSC_RUN,
  output logic             SLOW_OSC_RUN,
  output logic [3:0]       FAST_DIV_CODE,
  output logic [4:0]       FAST_DIV_RATIO,
  output logic [10:0]      FAST_TRIM,
  output logic [9:0]       SLOW_TRIM
);
  // two-flop synchronisers for the asynchronous inputs
  localparam int NSYNC = 7;
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;
  wire  [NSYNC-1:0] async_in = {FAST_OSC_ENABLE, SLOW_OSC_ENABLE, DEEP_LOW_POWER_STATE,
                                WAKE_EVENT, FAST_OSC_TICK, SLOW_OSC_TICK, CPU_RESET_ENABLE_A};

  genvar g;
  generate
    for (g = 0; g < NSYNC; g++) begin : g_sync
      always_ff @(posedge CORE_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          sync1_q[g] <= 1'b0;
          sync2_q[g] <= 1'b0;
        end else begin
          sync1_q[g] <= async_in[g];
          sync2_q[g] <= sync1_q[g];
        end
      end
    end
  endgenerate

  wire fast_en_s  = sync2_q[6];
  wire slow_en_s  = sync2_q[5];
  wire sleep_s    = sync2_q[4];
  wire wake_s     = sync2_q[3];
  wire fast_tk_s  = sync2_q[2];
  wire slow_tk_s  = sync2_q[1];
  wire reset_enable_a_s   = sync2_q[0];

  // edge detectors read only second-stage flops
  logic fast_tk_q;
  logic slow_tk_q;
  logic wake_q;
  wire  fast_tick = fast_tk_s & ~fast_tk_q;
  wire  slow_tick = slow_tk_s & ~slow_tk_q;
  wire  wake_rise = wake_s & ~wake_q;

  // register state
  logic [2:0]  wait_q;
  logic        wake_sel_q;
  logic        lock_en_q;
  logic        dbg_gpio_q;
  logic [3:0]  div_q;
  logic [10:0] ftrim_q;
  logic [1:0]  settle_q;
  logic [9:0]  strim_q;
  logic [31:0] rdata_q;

  // decode
  wire sel_ctrl2 = (ADDR == `SCC_OFS_CTRL2);
  wire sel_fast  = (ADDR == `SCC_OFS_FAST);
  wire sel_slow  = (ADDR == `SCC_OFS_SLOW);
  wire key_ok    = (WDATA[`SCC_KEY_MSB:`SCC_KEY_LSB] == `SCC_KEY_VAL);
  wire wr_ctrl2  = WR & sel_ctrl2 & key_ok;
  wire wr_fast   = WR & sel_fast;
  wire wr_slow   = WR & sel_slow;

  // divider codes outside the table are ignored, keeping the old value
  wire [3:0] div_new = WDATA[`SCC_DIV_MSB:`SCC_DIV_LSB];
  logic [4:0] div_ratio_w;
  always_comb begin
    unique case (div_q)
      4'h5:    div_ratio_w = 5'h06;
      4'h6:    div_ratio_w = 5'h01;
      4'h8:    div_ratio_w = 5'h02;
      4'h9:    div_ratio_w = 5'h04;
      4'hb:    div_ratio_w = 5'h08;
      4'hc:    div_ratio_w = 5'h0a;
      4'hd:    div_ratio_w = 5'h0c;
      4'he:    div_ratio_w = 5'h0e;
      4'hf:    div_ratio_w = 5'h10;
      default: div_ratio_w = 5'h06;
    endcase
  end
  wire div_legal = (div_new == 4'h5) | (div_new == 4'h6) | (div_new == 4'h8) |
                   (div_new == 4'h9) | (div_new >= 4'hb);

  // slow oscillator settle length
  logic [8:0] slow_settle_w;
  always_comb begin
    unique case (settle_q)
      2'h0: slow_settle_w = `SCC_SET0;
      2'h1: slow_settle_w = `SCC_SET1;
      2'h2: slow_settle_w = `SCC_SET2;
      2'h3: slow_settle_w = `SCC_SET3;
    endcase
  end

  // fast oscillator is cut in deep sleep; slow one is not
  wire fast_run_w = fast_en_s & ~sleep_s;
  wire slow_run_w = slow_en_s;

  wire fast_stable;
  wire slow_stable;

  scc_osc_settle u_fast_settle (
    .clk           (CORE_CLK),
    .rst_n         (RESET_N),
    .enable        (fast_run_w),
    .osc_tick      (fast_tick),
    .settle_cycles (`SCC_FAST_SETTLE),
    .stable        (fast_stable)
  );

  scc_osc_settle u_slow_settle (
    .clk           (CORE_CLK),
    .rst_n         (RESET_N),
    .enable        (slow_run_w),
    .osc_tick      (slow_tick),
    .settle_cycles (slow_settle_w),
    .stable        (slow_stable)
  );

  // read mux; reserved and unmapped read as zero
  wire [31:0] rd_ctrl2 = {25'h0, wait_q, wake_sel_q, lock_en_q, dbg_gpio_q, 1'b0};
  wire [31:0] rd_fast  = {16'h0, fast_stable, div_q, ftrim_q};
  wire [31:0] rd_slow  = {16'h0, slow_stable, 3'h0, settle_q, strim_q};
  wire [31:0] rd_mux   = sel_ctrl2 ? rd_ctrl2 :
                         sel_fast  ? rd_fast  :
                         sel_slow  ? rd_slow  : 32'h0;

  // wait field: 000->1, 001->2, 010->3 cycles; encoded as extra cycles 0..2
  wire [1:0] wait_cycles_w = (wait_q[2:1] != 2'b00) ? 2'h2 : {1'b0, wait_q[0]};

  // wake forcing: latch at wake edge, hold until next sleep entry
  logic force_fast_q;
  wire  force_fast_d = (wake_rise & wake_sel_q) ? 1'b1 :
                       (sleep_s ? 1'b0 : force_fast_q);

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fast_tk_q <= 1'b0;
      slow_tk_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      fast_tk_q <= fast_tk_s;
      slow_tk_q <= slow_tk_s;
      wake_q    <= wake_s;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wait_q     <= `SCC_CTRL2_RST;
      wake_sel_q <= 1'b0;
      lock_en_q  <= 1'b0;
      dbg_gpio_q <= 1'b0;
    end else if (wr_ctrl2) begin
      wait_q     <= WDATA[`SCC_WAIT_MSB:`SCC_WAIT_LSB];
      wake_sel_q <= WDATA[`SCC_WAKE_BIT];
      lock_en_q  <= WDATA[`SCC_LOCK_BIT];
      dbg_gpio_q <= WDATA[`SCC_DBG_BIT];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div_q   <= `SCC_DIV_RST;
      ftrim_q <= `SCC_FTRIM_RST;
    end else if (wr_fast) begin
      if (div_legal) div_q <= div_new;
      ftrim_q <= WDATA[`SCC_FTRIM_MSB:0];
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      settle_q <= `SCC_SETTLE_RST;
      strim_q  <= `SCC_STRIM_RST;
    end else if (wr_slow) begin
      settle_q <= WDATA[`SCC_SETTLE_MSB:`SCC_SETTLE_LSB];
      strim_q  <= WDATA[`SCC_STRIM_MSB:0];
    end
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rdata_q <= 32'h0;
    end else begin
      rdata_q <= RD ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      force_fast_q <= 1'b0;
    end else begin
      force_fast_q <= force_fast_d;
    end
  end

  // registered outputs; one short flop block per pin
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FETCH_WAIT_CYCLES <= 2'h0;
    end else begin
      FETCH_WAIT_CYCLES <= wait_cycles_w;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FORCE_FAST_CLOCK <= 1'b0;
    end else begin
      FORCE_FAST_CLOCK <= force_fast_q;
    end
  end

  // a level, not a pulse: the reset controller decides how long to act
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      RESET_ENABLE_A_RESET_REQ <= 1'b0;
    end else begin
      RESET_ENABLE_A_RESET_REQ <= reset_enable_a_s & lock_en_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      DEBUG_PINS_GPIO <= 1'b0;
    end else begin
      DEBUG_PINS_GPIO <= dbg_gpio_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_OSC_RUN <= 1'b0;
    end else begin
      FAST_OSC_RUN <= fast_run_w;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SLOW_OSC_RUN <= 1'b0;
    end else begin
      SLOW_OSC_RUN <= slow_run_w;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_DIV_CODE <= `SCC_DIV_RST;
    end else begin
      FAST_DIV_CODE <= div_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_DIV_RATIO <= 5'h06;
    end else begin
      FAST_DIV_RATIO <= div_ratio_w;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      FAST_TRIM <= `SCC_FTRIM_RST;
    end else begin
      FAST_TRIM <= ftrim_q;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      SLOW_TRIM <= `SCC_STRIM_RST;
    end else begin
      SLOW_TRIM <= strim_q;
    end
  end

  assign RDATA = rdata_q;
endmodule

// ==== tb/scc_regs_chk.sv ====
// assertions on the clock control register ports
// assumes binding into scc_regs, one clock domain
`timescale 1ns/100ps
module scc_regs_chk (
  input wire logic        CORE_CLK,
  input wire logic        RESET_N,
  input wire logic [7:0]  ADDR,
  input wire logic [31:0] WDATA,
  input wire logic        WR,
  input wire logic        RD,
  input wire logic [31:0] RDATA,
  input wire logic        SLOW_OSC_ENABLE,
  input wire logic        DEEP_LOW_POWER_STATE,
  input wire logic        CPU_RESET_ENABLE_A,
  input wire logic [1:0]  FETCH_WAIT_CYCLES,
  input wire logic        RESET_ENABLE_A_RESET_REQ,
  input wire logic        DEBUG_PINS_GPIO,
  input wire logic        FAST_OSC_RUN,
  input wire logic [3:0]  FAST_DIV_CODE,
  input wire logic [10:0] FAST_TRIM,
  input wire logic [9:0]  SLOW_TRIM
);
  wire key_wr = WR && ADDR == 8'h08 && WDATA[31:16] == 16'h5a5a;
  wire bad_wr = WR && ADDR == 8'h08 && WDATA[31:16] != 16'h5a5a;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);
  // six cycles covers the enable synchroniser
  sequence slow_off_read;
    (!SLOW_OSC_ENABLE)[*6] ##0 (RD && ADDR == 8'h20);
  endsequence
  key_guard_a: assert property (bad_wr && !$past(WR) |-> ##2
    $stable(DEBUG_PINS_GPIO) && $stable(FETCH_WAIT_CYCLES)) else $error("locked write acted");
  wait_map_a: assert property (key_wr |-> ##2 FETCH_WAIT_CYCLES ==
    ($past(WDATA[6:4], 2) > 3'h2 ? 2'h2 : $past(WDATA[5:4], 2))) else $error("wait field wrong");
  lock_gate_a: assert property ((!CPU_RESET_ENABLE_A)[*5] |-> !RESET_ENABLE_A_RESET_REQ)
    else $error("reset_enable_a reset without reset_enable_a");
  dbg_map_a: assert property (key_wr |-> ##2 DEBUG_PINS_GPIO == $past(WDATA[1], 2))
    else $error("debug pin select wrong");
  fast_view_a: assert property (RD && ADDR == 8'h18 |=>
    RDATA[31:16] == 16'h0 && RDATA[14:0] == {FAST_DIV_CODE, FAST_TRIM}) else $error("fast read");
  slow_view_a: assert property (RD && ADDR == 8'h20 |=>
    RDATA[31:16] == 16'h0 && RDATA[9:0] == SLOW_TRIM) else $error("slow read");
  fast_sleep_a: assert property (DEEP_LOW_POWER_STATE[*5] |-> !FAST_OSC_RUN)
    else $error("fast oscillator runs in sleep");
  slow_clear_a: assert property (slow_off_read |=> !RDATA[15])
    else $error("slow stable while disabled");
endmodule
bind scc_regs scc_regs_chk scc_regs_chk_inst (.*);

// ==== tb/scc_regs_bench.sv ====
// bench for the clock control register block
// assumes scc_regs with a one-cycle read port
`timescale 1ns/100ps
module scc_regs_bench;
  logic        CORE_CLK, RESET_N, WR, RD, FAST_OSC_ENABLE, SLOW_OSC_ENABLE, WAKE_EVENT;
  logic        DEEP_LOW_POWER_STATE, FAST_OSC_TICK, SLOW_OSC_TICK, CPU_RESET_ENABLE_A;
  logic        FORCE_FAST_CLOCK, RESET_ENABLE_A_RESET_REQ, DEBUG_PINS_GPIO, FAST_OSC_RUN, SLOW_OSC_RUN;
  logic [7:0]  ADDR;
  logic [31:0] WDATA, RDATA, cr2, fast, slow, d;
  logic [1:0]  FETCH_WAIT_CYCLES;
  logic [3:0]  FAST_DIV_CODE;
  logic [4:0]  FAST_DIV_RATIO;
  logic [10:0] FAST_TRIM;
  logic [9:0]  SLOW_TRIM;
  int          num_errors, checks, seed, i;
  int          ratio [16] = '{0, 0, 0, 0, 0, 6, 1, 0, 2, 4, 0, 8, 10, 12, 14, 16};
  int          settle [4] = '{6, 18, 66, 258};
  scc_regs scc_regs_inst (.*);
  initial begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge CORE_CLK);
  endtask
  task automatic look(input int k);
    cyc(k);
    @(negedge CORE_CLK);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    cyc(1);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    cyc(1);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    cyc(1);
    ADDR <= a;
    RD <= 1'b1;
    cyc(1);
    RD <= 1'b0;
    @(negedge CORE_CLK);
    chk("rdata", RDATA, exp);
  endtask
  // both oscillators tick together, eight clocks a cycle
  task automatic ticks(input int k);
    repeat (k) begin
      cyc(1);
      {FAST_OSC_TICK, SLOW_OSC_TICK} <= 2'b11;
      cyc(4);
      {FAST_OSC_TICK, SLOW_OSC_TICK} <= 2'b00;
      cyc(3);
    end
  endtask
  task automatic summarize;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    cyc(60000);
    num_errors++;
    summarize();
  end
  initial begin
    seed = 49;
    {RESET_N, WR, RD, FAST_OSC_ENABLE, SLOW_OSC_ENABLE, WAKE_EVENT} = '0;
    {DEEP_LOW_POWER_STATE, FAST_OSC_TICK, SLOW_OSC_TICK, CPU_RESET_ENABLE_A} = '0;
    ADDR = 8'h00;
    WDATA = 32'h0;
    cr2 = 32'h0;
    fast = 32'h2c00;
    slow = 32'h200;
    cyc(16);
    RESET_N <= 1'b1;
    rd(8'h08, cr2);
    rd(8'h10, 32'h0);
    chk("ratio", FAST_DIV_RATIO, 6);
    for (i = 0; i < 16; i++) begin
      d = $random(seed) & 32'hffff007e;
      d[6:4] = i[2:0];
      if (i[3]) d[31:16] = 16'h5a5a;
      wr(8'h08, d);
      if (d[31:16] == 16'h5a5a) cr2 = d & 32'h7e;
      look(2);
      chk("wait", FETCH_WAIT_CYCLES, cr2[6:4] > 3'h2 ? 2 : cr2[5:4]);
      chk("gpio", DEBUG_PINS_GPIO, cr2[1]);
      rd(8'h08, cr2);
    end
    for (i = 0; i < 16; i++) begin
      d = $random(seed) & 32'h7ff;
      d[14:11] = i[3:0];
      wr(8'h18, d);
      if (ratio[i] != 0) fast[14:11] = i[3:0];
      fast[10:0] = d[10:0];
      look(2);
      chk("ratio", FAST_DIV_RATIO, ratio[fast[14:11]]);
      rd(8'h18, fast);
    end
    // stand-in for the stored calibration word, copied in as software would
    fast[10:0] = 11'h5b3;
    wr(8'h18, fast);
    look(2);
    chk("fast trim", FAST_TRIM, fast[10:0]);
    for (i = 0; i < 4; i++) begin
      slow = $random(seed) & 32'h3ff;
      slow[11:10] = i[1:0];
      wr(8'h20, slow);
      SLOW_OSC_ENABLE <= 1'b1;
      cyc(4);
      ticks(settle[i] - 1);
      rd(8'h20, slow);
      chk("slow trim", SLOW_TRIM, slow[9:0]);
      ticks(1);
      look(4);
      rd(8'h20, slow | 32'h8000);
      cyc(1);
      SLOW_OSC_ENABLE <= 1'b0;
      look(6);
      rd(8'h20, slow);
    end
    cyc(1);
    {FAST_OSC_ENABLE, SLOW_OSC_ENABLE} <= 2'b11;
    ticks(260);
    look(4);
    rd(8'h18, fast | 32'h8000);
    cyc(1);
    DEEP_LOW_POWER_STATE <= 1'b1;
    look(6);
    chk("fast run", FAST_OSC_RUN, 0);
    chk("slow run", SLOW_OSC_RUN, 1);
    rd(8'h18, fast);
    rd(8'h20, slow | 32'h8000);
    for (i = 0; i < 2; i++) begin
      cr2[3:2] = {2{i[0]}};
      wr(8'h08, 32'h5a5a0000 | cr2);
      cyc(1);
      DEEP_LOW_POWER_STATE <= 1'b1;
      CPU_RESET_ENABLE_A <= 1'b1;
      cyc(6);
      WAKE_EVENT <= 1'b1;
      DEEP_LOW_POWER_STATE <= 1'b0;
      look(8);
      chk("force", FORCE_FAST_CLOCK, cr2[3]);
      chk("reset_enable_a", RESET_ENABLE_A_RESET_REQ, cr2[2]);
      cyc(1);
      {WAKE_EVENT, CPU_RESET_ENABLE_A} <= 2'b00;
    end
    summarize();
  end
endmodule
